// File: src/msc_pkg.sv
// Shared constants and types of the module state controller and its gate end.
package msc_pkg;
   localparam int MSC_NUM_MODULES = 40;
   localparam int MSC_EMU_MODULE = 39;
   // Software port map, byte addresses on a 12-bit address.
   localparam logic [11:0] MSC_ADDR_GO = 12'h120;
   localparam logic [11:0] MSC_ADDR_PENDING = 12'h128;
   localparam logic [3:0] MSC_PAGE_REPORT = 4'h8;
   localparam logic [3:0] MSC_PAGE_REQUEST = 4'ha;
   // Request register fields.
   localparam int MSC_REQ_STATE_IE = 10;
   localparam int MSC_REQ_RESET_IE = 9;
   localparam int MSC_REQ_LOCAL_RESET_CONTROL = 8;
   localparam int MSC_REQ_NEXT_LSB = 0;
   localparam int MSC_REQ_NEXT_W = 3;
   // Report register fields.
   localparam int MSC_REP_EMU_STATE = 17;
   localparam int MSC_REP_EMU_RESET = 16;
   localparam int MSC_REP_CLK = 12;
   localparam int MSC_REP_FIXED_ONE = 11;
   localparam int MSC_REP_MODULE_RESET_RELEASED = 10;
   localparam int MSC_REP_LOCAL_RESET_CONTROL_DONE = 9;
   localparam int MSC_REP_LOCAL_RESET_CONTROL = 8;
   localparam int MSC_REP_STATE_W = 6;
   localparam int MSC_GO_BIT = 0;
   // Module states; bit 0 is clock on, bit 1 is reset released.
   localparam logic [1:0] MSC_ST_SWRST_DISABLED = 2'h0;
   localparam logic [1:0] MSC_ST_SYNC_RESET = 2'h1;
   localparam logic [1:0] MSC_ST_DISABLED = 2'h2;
   localparam logic [1:0] MSC_ST_ENABLED = 2'h3;
   localparam logic [5:0] MSC_ST_TRANS_BASE = 6'h08;
   // Reset values.
   localparam logic MSC_LOCAL_RESET_CONTROL_RESET = 1'b1;
   localparam logic [2:0] MSC_NEXT_RESET = 3'h0;
   // Timing at the 25 MHz clock.
   localparam int MSC_CLK_NS = 40;
   localparam int MSC_LOCAL_RESET_CONTROL_DONE_NS = 200;
   localparam int MSC_LOCAL_RESET_CONTROL_DONE_CYCLES = (MSC_LOCAL_RESET_CONTROL_DONE_NS + MSC_CLK_NS - 1) / MSC_CLK_NS;
   localparam int MSC_SETTLE_CYCLES = 2;
   typedef enum logic [1:0] {MSC_IDLE, MSC_SETTLE, MSC_WAIT} msc_fsm_t;
endpackage : msc_pkg

// File: src/msc_link_if.sv
// Link between the state controller and the gate end of the managed modules.
`timescale 1ns/1ns
interface msc_link_if #(parameter int N = 40);
   logic [N-1:0] clk_en;
   logic [N-1:0] rst_n;
   logic local_rst_n;
   logic [N-1:0] clk_on;
   logic [N-1:0] rst_rel;
   logic local_rst_rel;
   logic local_rst_done;
   logic emu_state_force;
   logic emu_reset_force;
   modport ctl (output clk_en, rst_n, local_rst_n,
                input clk_on, rst_rel, local_rst_rel, local_rst_done, emu_state_force, emu_reset_force);
   modport gate (input clk_en, rst_n, local_rst_n,
                 output clk_on, rst_rel, local_rst_rel, local_rst_done, emu_state_force, emu_reset_force);
endinterface : msc_link_if

// File: src/msc_ctrl.sv
// Module state controller: request and report registers, transitions and override flags.
`timescale 1ns/1ns
module msc_ctrl
   import msc_pkg::*;
#(
   parameter int N = MSC_NUM_MODULES,
   parameter int EMU_MOD = MSC_EMU_MODULE
) (
   input wire logic i_mclk, // System clock.
   input wire logic i_reset_n, // Synchronous reset, active low.
   input wire logic [11:0] i_addr, // Software byte address.
   input wire logic [31:0] i_wdata, // Software write data.
   input wire logic i_wr, // Write strobe.
   input wire logic i_rd, // Read strobe.
   output logic [31:0] o_rdata, // Read data, valid the cycle after i_rd.
   output logic o_controller_interrupt, // Emulation override interrupt, level.
   output logic o_domain_transition_pending, // High while a transition runs.
   msc_link_if.ctl link // Clock and reset link to the gate end.
);
   typedef struct packed {
      logic [N-1:0][2:0] next;
      logic [N-1:0] state_ie;
      logic [N-1:0] reset_ie;
      logic [N-1:0] local_reset_control;
      logic [N-1:0][5:0] state;
      logic [N-1:0][1:0] target;
      logic [N-1:0] mism;
      msc_fsm_t fsm;
      logic [1:0] settle;
      logic pending;
      logic [N-1:0] clk_en;
      logic [N-1:0] rst_n;
      logic local_rst_n;
      logic emu_state_flag;
      logic emu_reset_flag;
      logic irq;
      logic [31:0] rdata;
   } msc_ctrl_st_t;

   msc_ctrl_st_t q;
   msc_ctrl_st_t d;

   logic [5:0] idx;
   logic in_range;
   logic on_request;
   logic on_report;
   logic wr_request;
   logic rd_report;
   logic rd_request;
   logic rd_pending;
   logic go_cmd;
   logic echo_match;
   logic state_override;
   logic reset_override;
   logic [1:0] go_target [N];
   logic go_mism [N];
   logic [31:0] rep_word [N];
   logic [31:0] req_word [N];

   assign link.clk_en = q.clk_en;
   assign link.rst_n = q.rst_n;
   assign link.local_rst_n = q.local_rst_n;
   assign o_rdata = q.rdata;
   assign o_controller_interrupt = q.irq;
   assign o_domain_transition_pending = q.pending;

   // Only aligned words inside the forty-entry range decode; every other address except the pending word reads as zero.
   assign idx = i_addr[7:2];
   assign in_range = (int'(idx) < N) && (i_addr[1:0] == 2'h0);
   assign on_request = in_range && (i_addr[11:8] == MSC_PAGE_REQUEST);
   assign on_report = in_range && (i_addr[11:8] == MSC_PAGE_REPORT);
   assign wr_request = i_wr && on_request;
   assign rd_report = i_rd && on_report;
   assign rd_request = i_rd && on_request;
   assign rd_pending = i_rd && (i_addr == MSC_ADDR_PENDING);
   assign go_cmd = i_wr && (i_addr == MSC_ADDR_GO) && i_wdata[MSC_GO_BIT];
   // The gate end answers one edge late, so the echo is only trusted after settling.
   assign echo_match = (link.clk_on == q.clk_en) && (link.rst_rel == q.rst_n);
   assign state_override = link.emu_state_force && (q.next[EMU_MOD][1:0] != MSC_ST_ENABLED);
   assign reset_override = link.emu_reset_force && !q.local_reset_control[EMU_MOD];

   for (genvar g = 0; g < N; g++) begin : g_mod
      // Emulation keeps the processor module enabled; reserved next codes fold onto the low two bits.
      assign go_target[g] = (g == EMU_MOD && link.emu_state_force) ? MSC_ST_ENABLED : q.next[g][1:0];
      assign go_mism[g] = (q.state[g] != {4'h0, go_target[g]});
      // Modules without a local reset read it as done and released.
      always_comb begin
         rep_word[g] = '0;
         rep_word[g][MSC_REP_STATE_W-1:0] = q.state[g];
         rep_word[g][MSC_REP_CLK] = link.clk_on[g];
         rep_word[g][MSC_REP_FIXED_ONE] = 1'b1;
         rep_word[g][MSC_REP_MODULE_RESET_RELEASED] = link.rst_rel[g];
         rep_word[g][MSC_REP_EMU_STATE] = (g == EMU_MOD) && q.emu_state_flag;
         rep_word[g][MSC_REP_EMU_RESET] = (g == EMU_MOD) && q.emu_reset_flag;
         rep_word[g][MSC_REP_LOCAL_RESET_CONTROL_DONE] = (g != EMU_MOD) || link.local_rst_done;
         rep_word[g][MSC_REP_LOCAL_RESET_CONTROL] = (g != EMU_MOD) || link.local_rst_rel;
      end
      always_comb begin
         req_word[g] = '0;
         req_word[g][MSC_REQ_NEXT_LSB +: MSC_REQ_NEXT_W] = q.next[g];
         req_word[g][MSC_REQ_LOCAL_RESET_CONTROL] = q.local_reset_control[g];
         req_word[g][MSC_REQ_STATE_IE] = q.state_ie[g];
         req_word[g][MSC_REQ_RESET_IE] = q.reset_ie[g];
      end
   end

   always_comb begin
      d = q;
      // Read data stand for one cycle and then fall back to zero.
      d.rdata = '0;
      // The flags follow the override live, so they clear on their own once it ends.
      d.emu_state_flag = state_override;
      d.emu_reset_flag = reset_override;
      d.irq = (q.emu_state_flag && q.state_ie[EMU_MOD])
              || (q.emu_reset_flag && q.reset_ie[EMU_MOD]);
      d.local_rst_n = q.local_reset_control[EMU_MOD] || link.emu_reset_force;

      // Enable and local reset bits are kept for every module, but only module 39 acts on them.
      if (wr_request) begin
         d.next[idx] = i_wdata[MSC_REQ_NEXT_LSB +: MSC_REQ_NEXT_W];
         d.local_reset_control[idx] = i_wdata[MSC_REQ_LOCAL_RESET_CONTROL];
         d.state_ie[idx] = i_wdata[MSC_REQ_STATE_IE];
         d.reset_ie[idx] = i_wdata[MSC_REQ_RESET_IE];
      end

      unique case (q.fsm)
         MSC_IDLE: begin
            // A go written while a transition runs is dropped; software polls pending first.
            if (go_cmd) begin
               for (int i = 0; i < N; i++) begin
                  d.target[i] = go_target[i];
                  d.mism[i] = go_mism[i];
                  if (go_mism[i]) begin
                     d.state[i] = MSC_ST_TRANS_BASE | {4'h0, go_target[i]};
                     d.clk_en[i] = go_target[i][0];
                     d.rst_n[i] = go_target[i][1];
                  end
               end
               d.pending = 1'b1;
               d.settle = '0;
               d.fsm = MSC_SETTLE;
            end
         end
         MSC_SETTLE: begin
            // Give the gate end time to register the new enables before comparing.
            d.settle = q.settle + 2'd1;
            if (int'(q.settle) == MSC_SETTLE_CYCLES - 1) begin
               d.fsm = MSC_WAIT;
            end
         end
         MSC_WAIT: begin
            if (echo_match) begin
               for (int i = 0; i < N; i++) begin
                  if (q.mism[i]) begin
                     d.state[i] = {4'h0, q.target[i]};
                  end
               end
               d.mism = '0;
               d.pending = 1'b0;
               d.fsm = MSC_IDLE;
            end
         end
      endcase

      // The report shows the gate end's echo, not the request, so software sees the real condition.
      if (rd_report) begin
         d.rdata = rep_word[idx];
      end else if (rd_request) begin
         d.rdata = req_word[idx];
      end else if (rd_pending) begin
         d.rdata[0] = q.pending;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_reset_n) begin
         q <= '0;
         for (int i = 0; i < N; i++) begin
            q.next[i] <= MSC_NEXT_RESET;
         end
         q.local_reset_control <= {N{MSC_LOCAL_RESET_CONTROL_RESET}};
         q.local_rst_n <= MSC_LOCAL_RESET_CONTROL_RESET;
         q.fsm <= MSC_IDLE;
      end else begin
         q <= d;
      end
   end
endmodule : msc_ctrl

// File: src/msc_gate.sv
// Gate end: applies clock and reset enables to the modules and reports their real condition.
`timescale 1ns/1ns
module msc_gate
   import msc_pkg::*;
#(
   parameter int N = MSC_NUM_MODULES,
   parameter int LOCAL_RESET_CONTROL_DONE_CYCLES = MSC_LOCAL_RESET_CONTROL_DONE_CYCLES
) (
   input wire logic i_mclk, // System clock.
   input wire logic i_reset_n, // Synchronous reset, active low.
   input wire logic i_emu_state_force, // Emulator holds module 39 enabled.
   input wire logic i_emu_reset_force, // Emulator holds module 39 out of local reset.
   output logic [N-1:0] o_mod_clk_en, // Per-module clock enable.
   output logic [N-1:0] o_mod_rst_n, // Per-module reset, active low.
   output logic o_local_rst_n, // Module 39 local reset, active low.
   msc_link_if.gate link // Link to the controller.
);
   typedef struct packed {
      logic [N-1:0] clk;
      logic [N-1:0] rst_n;
      logic local_reset_control_n;
      logic done;
      logic [7:0] cnt;
      logic emu_state_meta;
      logic emu_reset_meta;
      logic emu_state;
      logic emu_reset;
   } msc_gate_st_t;

   msc_gate_st_t q;
   msc_gate_st_t d;

   assign o_mod_clk_en = q.clk;
   assign o_mod_rst_n = q.rst_n;
   assign o_local_rst_n = q.local_reset_control_n;
   assign link.clk_on = q.clk;
   assign link.rst_rel = q.rst_n;
   assign link.local_rst_rel = q.local_reset_control_n;
   assign link.local_rst_done = q.done;
   assign link.emu_state_force = q.emu_state;
   assign link.emu_reset_force = q.emu_reset;

   always_comb begin
      d = q;
      d.clk = link.clk_en;
      d.rst_n = link.rst_n;
      d.local_reset_control_n = link.local_rst_n;
      // Emulator requests come from outside this clock, so they pass two flops before use.
      d.emu_state_meta = i_emu_state_force;
      d.emu_reset_meta = i_emu_reset_force;
      d.emu_state = q.emu_state_meta;
      d.emu_reset = q.emu_reset_meta;
      // Done comes a fixed time after release, so software never sees it early.
      if (!q.local_reset_control_n) begin
         d.cnt = '0;
         d.done = 1'b0;
      end else if (!q.done) begin
         d.cnt = q.cnt + 8'd1;
         d.done = (int'(q.cnt) >= LOCAL_RESET_CONTROL_DONE_CYCLES - 1);
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_reset_n) begin
         q <= '0;
         q.local_reset_control_n <= MSC_LOCAL_RESET_CONTROL_RESET;
      end else begin
         q <= d;
      end
   end
endmodule : msc_gate

// File: dv/msc_asserts.sv
// Checker of the link between the state controller and its gate end.
`timescale 1ns/1ns
module msc_asserts #(parameter int N = 40) (
   input wire logic i_mclk, // Clock.
   input wire logic i_reset_n, // Reset, active low.
   input wire logic [N-1:0] clk_en, // Clock enables.
   input wire logic [N-1:0] rst_n, // Module resets.
   input wire logic local_rst_n, // Local reset.
   input wire logic [N-1:0] clk_on, // Clock echo.
   input wire logic [N-1:0] rst_rel, // Reset echo.
   input wire logic local_rst_rel, // Local reset echo.
   input wire logic local_rst_done, // Local reset done.
   input wire logic emu_reset_force // Reset override.
);
   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_reset_n);
   sequence s_local_reset_control_cycle;
      !local_rst_rel [*2] ##1 local_rst_rel;
   endsequence
   property p_clk_echo;
      clk_on == $past(clk_en);
   endproperty
   property p_rst_echo;
      rst_rel == $past(rst_n);
   endproperty
   property p_local_reset_control_echo;
      local_rst_rel == $past(local_rst_n);
   endproperty
   property p_done_low;
      !local_rst_rel [*2] |-> !local_rst_done;
   endproperty
   property p_done_wait;
      s_local_reset_control_cycle |-> !local_rst_done ##1 !local_rst_done;
   endproperty
   property p_done_rise;
      local_rst_rel [*8] |-> local_rst_done;
   endproperty
   property p_emu_local_reset_control;
      emu_reset_force |=> local_rst_n;
   endproperty
   property p_hold;
      $stable(clk_en) && $stable(rst_n) |=> $stable(clk_on) && $stable(rst_rel);
   endproperty
   a_clk_echo: assert property (p_clk_echo) else $error("clock echo wrong");
   a_rst_echo: assert property (p_rst_echo) else $error("reset echo wrong");
   a_local_reset_control_echo: assert property (p_local_reset_control_echo) else $error("local echo wrong");
   a_done_low: assert property (p_done_low) else $error("done while held");
   a_done_wait: assert property (p_done_wait) else $error("done too early");
   a_done_rise: assert property (p_done_rise) else $error("done too late");
   a_emu_local_reset_control: assert property (p_emu_local_reset_control) else $error("override ignored");
   a_hold: assert property (p_hold) else $error("echo moved");
endmodule : msc_asserts

// File: dv/tb.sv
// Self-checking bench for the state controller and its gate end.
`timescale 1ns/1ns
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin error_cnt++; $display("mismatch %0t got %0h want %0h", $time, (a), (e)); end end
module tb;
   import msc_pkg::*;
   logic i_mclk = 0, i_reset_n = 0, i_wr = 0, i_rd = 0, es = 0, er = 0;
   logic [11:0] i_addr = '0;
   logic [31:0] i_wdata = '0, rdata, v;
   logic irq, pend, lrstn;
   logic [39:0] clk_out, rstn_out;
   int error_cnt = 0, n_compared = 0;
   msc_link_if #(.N(40)) lnk ();
   msc_ctrl i_msc_ctrl (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata), .o_controller_interrupt(irq),
      .o_domain_transition_pending(pend), .link(lnk));
   msc_gate i_msc_gate (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_emu_state_force(es),
      .i_emu_reset_force(er), .o_mod_clk_en(clk_out), .o_mod_rst_n(rstn_out), .o_local_rst_n(lrstn),
      .link(lnk));
   msc_asserts i_msc_asserts (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .clk_en(lnk.clk_en), .rst_n(lnk.rst_n),
      .local_rst_n(lnk.local_rst_n), .clk_on(lnk.clk_on), .rst_rel(lnk.rst_rel),
      .local_rst_rel(lnk.local_rst_rel), .local_rst_done(lnk.local_rst_done),
      .emu_reset_force(lnk.emu_reset_force));
   initial begin
      forever #20 i_mclk = ~i_mclk;
   end
   function automatic logic [11:0] rq(input int n);
      return {MSC_PAGE_REQUEST, 8'(n * 4)};
   endfunction : rq
   function automatic logic [11:0] rp(input int n);
      return {MSC_PAGE_REPORT, 8'(n * 4)};
   endfunction : rp
   function automatic logic [31:0] rep_exp(input logic [1:0] s);
      return 32'h0000_0B00 | {19'h0, s[0], 1'b0, s[1], 8'h0, s};
   endfunction : rep_exp
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge i_mclk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_mclk);
      i_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [11:0] a);
      @(posedge i_mclk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_mclk);
      i_rd <= 1'b0;
      #1 v = rdata;
   endtask : rd
   task automatic test_done;
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : test_done
   task automatic t_reset;
      rd(rp(0));
      `CHK(v, 32'h0000_0B00)
      rd(rp(39));
      `CHK(v, 32'h0000_0B00)
      rd(rq(39));
      `CHK(v, 32'h0000_0100)
      rd(rp(40));
      `CHK(v, 32'h0000_0000)
      wr(rq(39), 32'h0000_0703);
      rd(rq(39));
      `CHK(v, 32'h0000_0703)
      wr(rq(39), 32'h0000_0100);
      $display("reset test done");
   endtask : t_reset
   task automatic t_trans;
      int k;
      for (int i = 3; i >= 0; i--) begin
         wr(rq(7), 32'h0000_0100 | i);
         wr(rq(39), 32'h0000_0100 | i);
         wr(MSC_ADDR_GO, 32'h0000_0001);
         rd(rp(7));
         `CHK(v[5:0] >= 6'h04, 1'b1)
         `CHK(pend, 1'b1)
         k = 0;
         while (pend !== 1'b0 && k < 50) begin
            @(posedge i_mclk);
            #1 k++;
         end
         if (k == 50) begin
            error_cnt++;
            $display("mismatch %0t pending never cleared", $time);
            test_done;
         end
         rd(rp(7));
         `CHK(v, rep_exp(2'(i)))
         `CHK(clk_out[7], i[0])
         `CHK(rstn_out[7], i[1])
      end
      wr(MSC_ADDR_GO, 32'h0000_0001);
      rd(MSC_ADDR_PENDING);
      `CHK(v, 32'h0000_0001)
      rd(rp(3));
      `CHK(v, 32'h0000_0B00)
      $display("transition test done");
   endtask : t_trans
   task automatic t_local_reset_control;
      wr(rq(39), 32'h0000_0000);
      repeat (4) @(posedge i_mclk);
      rd(rp(39));
      `CHK(v[9:8], 2'b00)
      `CHK(lrstn, 1'b0)
      wr(rq(39), 32'h0000_0100);
      rd(rp(39));
      `CHK(v[9], 1'b0)
      repeat (10) @(posedge i_mclk);
      rd(rp(39));
      `CHK(v[9:8], 2'b11)
      $display("local reset test done");
   endtask : t_local_reset_control
   task automatic t_emu;
      wr(rq(39), 32'h0000_0402);
      es <= 1'b1;
      er <= 1'b1;
      repeat (4) @(posedge i_mclk);
      rd(rp(39));
      `CHK(v[17:16], 2'b11)
      `CHK(irq, 1'b1)
      rd(rp(5));
      `CHK(v[17:16], 2'b00)
      wr(MSC_ADDR_GO, 32'h0000_0001);
      repeat (4) @(posedge i_mclk);
      rd(rp(39));
      `CHK(v[5:0], 6'h03)
      `CHK(v[12:10], 3'b111)
      `CHK(clk_out[39], 1'b1)
      wr(rq(39), 32'h0000_0202);
      repeat (2) @(posedge i_mclk);
      #1 `CHK(irq, 1'b1)
      wr(rq(39), 32'h0000_0002);
      repeat (2) @(posedge i_mclk);
      es <= 1'b0;
      er <= 1'b0;
      #1 `CHK(irq, 1'b0)
      repeat (4) @(posedge i_mclk);
      rd(rp(39));
      `CHK(v[17:16], 2'b00)
      $display("emulation test done");
   endtask : t_emu
   initial begin
      repeat (3) @(posedge i_mclk);
      i_reset_n <= 1'b1;
      repeat (8) @(posedge i_mclk);
      t_reset;
      t_trans;
      t_local_reset_control;
      t_emu;
      test_done;
   end
endmodule : tb
